// ===== hw/secured_reg_word.sv
// one 16-bit secured register with write enable and reset value
`timescale 1ns/1ps
`default_nettype none

module secured_reg_word #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic write_en,
  input wire logic [WIDTH-1:0] write_data,
  output logic [WIDTH-1:0] value
);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else if (write_en) begin
      value <= write_data;
    end
  end

endmodule : secured_reg_word

`default_nettype wire

// ===== hw/secured_register_unlock.sv
// write protection and keyed unlock for the secured system registers
`timescale 1ns/1ps
`default_nettype none
`include "secured_register_unlock_regs.svh"

module secured_register_unlock
  import secured_register_unlock_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic end_of_init_instruction,
  input wire logic extended_range_lock,
  input wire logic instr_done,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [1:0] wr_kind,
  input wire logic [2:0] rd_sel,
  output logic [WIDTH-1:0] rd_data,
  output logic [WIDTH-1:0] main_system_config_reg,
  output logic [WIDTH-1:0] sleep_control_reg,
  output logic [WIDTH-1:0] clock_and_key_control_reg,
  output logic [WIDTH-1:0] peripheral_gating_reg,
  output logic [WIDTH-1:0] reset_config_reg,
  output logic [1:0] clock_select_field,
  output logic slowdown_select,
  output logic pll_run,
  output logic initialised,
  output logic unlocked
);

  function automatic logic sel_is_unlockable(input logic [2:0] sel);
    sel_is_unlockable = (sel == `SEL_SLEEP_CONTROL) ||
                        (sel == `SEL_CLOCK_AND_KEY_CONTROL) ||
                        (sel == `SEL_PERIPHERAL_GATING) ||
                        (sel == `SEL_RESET_CONFIG);
  endfunction : sel_is_unlockable

  unlock_state_type state;
  unlock_state_type next_state;
  access_kind_type kind;
  logic [2:0] range_left;
  logic [2:0] next_range_left;

  assign kind = access_kind_type'(wr_kind);

  wire key_write = wr_en && (wr_sel == `SEL_CLOCK_AND_KEY_CONTROL);
  wire [3:0] key_value = wr_data[`KEY_MSB:`KEY_LSB];
  wire in_range = extended_range_lock && (range_left != 3'h0);

  wire step1_ok = key_write && in_range && (kind == acc_rmw) &&
                  (key_value == `KEY_STEP1);
  wire step2_ok = key_write && in_range && (kind == acc_plain_write) &&
                  (key_value == `KEY_STEP2);
  wire step3_ok = key_write && in_range && (kind == acc_bit_rmw) &&
                  (key_value == `KEY_STEP3);

  wire grant_write = (state == unlock_key3) && wr_en && in_range &&
                     sel_is_unlockable(wr_sel) &&
                     (kind != acc_other);

  // the main config register is sealed for good once init ends
  wire allow_main = wr_en && !initialised &&
                    (wr_sel == `SEL_MAIN_SYSTEM_CONFIG);
  wire full_write = !initialised || grant_write;

  wire we_sleep = wr_en && (wr_sel == `SEL_SLEEP_CONTROL) && full_write;
  wire we_gate = wr_en && (wr_sel == `SEL_PERIPHERAL_GATING) &&
                 full_write;
  wire we_rstcfg = wr_en && (wr_sel == `SEL_RESET_CONFIG) &&
                   full_write;
  wire we_clk_full = key_write && full_write;
  // the key nibble stays writable while the rest is locked
  wire we_key_only = key_write && !full_write;

  wire [WIDTH-1:0] clk_wr_full =
    grant_write ? {wr_data[WIDTH-1:`KEY_MSB+1], `KEY_CLEARED} : wr_data;
  wire [WIDTH-1:0] clk_wr_key =
    {clock_and_key_control_reg[WIDTH-1:`KEY_MSB+1], key_value};
  // success clears the key even when another register was written
  wire [WIDTH-1:0] clk_wr_clear =
    {clock_and_key_control_reg[WIDTH-1:`KEY_MSB+1], `KEY_CLEARED};
  wire [WIDTH-1:0] clk_next =
    we_clk_full ? clk_wr_full : (we_key_only ? clk_wr_key :
                                 clk_wr_clear);
  wire we_clk = we_clk_full || we_key_only || grant_write;

  always_comb begin
    next_state = state;
    unique case (state)
      unlock_idle: begin
        if (step1_ok) begin
          next_state = unlock_key1;
        end
      end
      unlock_key1: begin
        if (step2_ok) begin
          next_state = unlock_key2;
        end else if (wr_en || !in_range) begin
          next_state = unlock_idle;
        end
      end
      unlock_key2: begin
        if (step3_ok) begin
          next_state = unlock_key3;
        end else if (wr_en || !in_range) begin
          next_state = unlock_idle;
        end
      end
      unlock_key3: begin
        if (wr_en || !in_range) begin
          next_state = unlock_idle;
        end
      end
      default: next_state = unlock_idle;
    endcase
    if (!initialised) begin
      next_state = unlock_idle;
    end
  end

  // the lock range counts instructions so a short range aborts
  always_comb begin
    if (!extended_range_lock) begin
      next_range_left = `EXT_RANGE_STEPS;
    end else if (instr_done && range_left != 3'h0) begin
      next_range_left = range_left - 3'h1;
    end else begin
      next_range_left = range_left;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= unlock_idle;
      range_left <= `EXT_RANGE_STEPS;
      initialised <= 1'b0;
    end else begin
      state <= next_state;
      range_left <= next_range_left;
      if (end_of_init_instruction) begin
        initialised <= 1'b1;
      end
    end
  end

  // storage words indexed by their selector code
  logic [4:0] reg_we;
  logic [WIDTH-1:0] reg_wdata [5];
  logic [WIDTH-1:0] reg_value [5];

  assign reg_we[`SEL_MAIN_SYSTEM_CONFIG] = allow_main;
  assign reg_we[`SEL_SLEEP_CONTROL] = we_sleep;
  assign reg_we[`SEL_CLOCK_AND_KEY_CONTROL] = we_clk;
  assign reg_we[`SEL_PERIPHERAL_GATING] = we_gate;
  assign reg_we[`SEL_RESET_CONFIG] = we_rstcfg;
  assign reg_wdata[`SEL_MAIN_SYSTEM_CONFIG] = wr_data;
  assign reg_wdata[`SEL_SLEEP_CONTROL] = wr_data;
  assign reg_wdata[`SEL_CLOCK_AND_KEY_CONTROL] = clk_next;
  assign reg_wdata[`SEL_PERIPHERAL_GATING] = wr_data;
  assign reg_wdata[`SEL_RESET_CONFIG] = wr_data;

  for (genvar i = 0; i < 5; i++) begin : g_word
    secured_reg_word #(.WIDTH(WIDTH), .RESET_VALUE(`RESET_VALUE)) u_word (
      .core_clk(core_clk),
      .rst(rst),
      .write_en(reg_we[i]),
      .write_data(reg_wdata[i]),
      .value(reg_value[i])
    );
  end

  assign main_system_config_reg = reg_value[`SEL_MAIN_SYSTEM_CONFIG];
  assign sleep_control_reg = reg_value[`SEL_SLEEP_CONTROL];
  assign clock_and_key_control_reg = reg_value[`SEL_CLOCK_AND_KEY_CONTROL];
  assign peripheral_gating_reg = reg_value[`SEL_PERIPHERAL_GATING];
  assign reset_config_reg = reg_value[`SEL_RESET_CONFIG];

  wire [1:0] clk_sel =
    clock_and_key_control_reg[`CLKSEL_MSB:`CLKSEL_LSB];
  assign clock_select_field = clk_sel;
  assign slowdown_select = (clk_sel != `CLKSEL_BASIC);
  // codes 00 and 01 keep the PLL; 10 and 11 stop it
  assign pll_run = (clk_sel == `CLKSEL_BASIC) ||
                   (clk_sel == `CLKSEL_SLOWDOWN_PLL_ON);
  // a lapsed lock range must not read as a usable grant
  assign unlocked = (state == unlock_key3) && in_range;

  // reads never depend on lock state
  always_comb begin
    unique case (rd_sel)
      `SEL_MAIN_SYSTEM_CONFIG: rd_data = main_system_config_reg;
      `SEL_SLEEP_CONTROL: rd_data = sleep_control_reg;
      `SEL_CLOCK_AND_KEY_CONTROL: rd_data = clock_and_key_control_reg;
      `SEL_PERIPHERAL_GATING: rd_data = peripheral_gating_reg;
      `SEL_RESET_CONFIG: rd_data = reset_config_reg;
      default: rd_data = '0;
    endcase
  end

endmodule : secured_register_unlock

`default_nettype wire

// ===== hw/secured_register_unlock_pkg.sv
// types shared by the secured register unlock block
package secured_register_unlock_pkg;

  typedef enum logic [1:0] {
    acc_plain_write = 2'b00,
    acc_rmw = 2'b01,
    acc_bit_rmw = 2'b10,
    acc_other = 2'b11
  } access_kind_type;

  typedef enum logic [2:0] {
    unlock_idle = 3'b000,
    unlock_key1 = 3'b001,
    unlock_key2 = 3'b010,
    unlock_key3 = 3'b011
  } unlock_state_type;

endpackage : secured_register_unlock_pkg

// ===== hw/secured_register_unlock_regs.svh
// register selectors, field positions, key values and reset values
`ifndef SECURED_REGISTER_UNLOCK_REGS_SVH
`define SECURED_REGISTER_UNLOCK_REGS_SVH

`define SEL_MAIN_SYSTEM_CONFIG 3'h0
`define SEL_SLEEP_CONTROL 3'h1
`define SEL_CLOCK_AND_KEY_CONTROL 3'h2
`define SEL_PERIPHERAL_GATING 3'h3
`define SEL_RESET_CONFIG 3'h4

`define KEY_LSB 0
`define KEY_MSB 3
`define CLKSEL_LSB 8
`define CLKSEL_MSB 9

`define KEY_STEP1 4'h9
`define KEY_STEP2 4'h3
`define KEY_STEP3 4'h7
`define KEY_CLEARED 4'h0

`define CLKSEL_BASIC 2'h0
`define CLKSEL_SLOWDOWN_PLL_ON 2'h1

`define RESET_VALUE 16'h0000
`define EXT_RANGE_STEPS 3'h4

`endif

// ===== test/secured_register_unlock_checker.sv
// assertions on the ports of the secured register unlock block
`timescale 1ns/1ps
`default_nettype none
module secured_register_unlock_checker #(parameter int WIDTH = 16) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic initialised,
  input wire logic unlocked,
  input wire logic extended_range_lock,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [1:0] wr_kind,
  input wire logic [WIDTH-1:0] main_system_config_reg,
  input wire logic [WIDTH-1:0] clock_and_key_control_reg,
  input wire logic [WIDTH-1:0] peripheral_gating_reg,
  input wire logic [WIDTH-1:0] reset_config_reg,
  input wire logic [1:0] clock_select_field,
  input wire logic slowdown_select,
  input wire logic pll_run
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  main_lock_a: assert property (
    initialised && wr_en && wr_sel == 3'h0 |=> $stable(main_system_config_reg))
    else $error("main config changed after init");
  gate_lock_a: assert property (
    initialised && !unlocked && wr_en && wr_sel == 3'h3
    |=> $stable(peripheral_gating_reg)) else $error("gating write not blocked");
  key_free_a: assert property (
    initialised && !unlocked && wr_en && wr_sel == 3'h2
    |=> clock_and_key_control_reg[3:0] == $past(wr_data[3:0]))
    else $error("key field not stored");
  grant_clear_a: assert property (
    initialised && unlocked && extended_range_lock && wr_en &&
    wr_sel inside {[3'h1:3'h4]} && wr_kind != 2'h3
    |=> !unlocked && clock_and_key_control_reg[3:0] == 4'h0)
    else $error("grant not single or key not cleared");
  clk_sel_a: assert property (
    clock_select_field == clock_and_key_control_reg[9:8] &&
    slowdown_select == (clock_select_field != 2'h0) &&
    pll_run == (clock_select_field <= 2'h1)) else $error("clock select wrong");
  range_drop_a: assert property (
    !extended_range_lock |=> !unlocked) else $error("unlocked without range");
  key_order_a: assert property (
    wr_en && (wr_sel != 3'h2 || wr_kind != 2'h2 || wr_data[3:0] != 4'h7)
    |=> !unlocked) else $error("unlocked by wrong step");
  pre_init_a: assert property (
    !initialised && wr_en && wr_sel == 3'h4
    |=> reset_config_reg == $past(wr_data)) else $error("early write lost");
endmodule : secured_register_unlock_checker
bind secured_register_unlock secured_register_unlock_checker #(.WIDTH(WIDTH))
  chk_u (.core_clk, .rst, .initialised, .unlocked, .extended_range_lock,
  .wr_en, .wr_sel, .wr_data, .wr_kind, .main_system_config_reg,
  .clock_and_key_control_reg, .peripheral_gating_reg, .reset_config_reg,
  .clock_select_field, .slowdown_select, .pll_run);
`default_nettype wire

// ===== test/secured_register_unlock_tb_top.sv
// self-checking bench for the secured register unlock block
`timescale 1ns/1ps
`default_nettype none
module secured_register_unlock_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, eoi = 1'b0, lock = 1'b0, done = 1'b0;
  logic wr_en = 1'b0, rd_go = 1'b0, init = 1'b0, slow, pll, ini, unl;
  logic [2:0] wr_sel = 3'h0, rd_sel = 3'h0;
  logic [15:0] wr_data = 16'h0000, rd_data, m [5], regs [5];
  logic [1:0] wr_kind = 2'h0, csel;
  logic [37:0] q [$];
  int errors = 0, checks = 0;
  always #5 core_clk = ~core_clk;
  secured_register_unlock dut_u (.core_clk, .rst,
    .end_of_init_instruction(eoi), .extended_range_lock(lock),
    .instr_done(done), .wr_en, .wr_sel, .wr_data, .wr_kind, .rd_sel,
    .rd_data, .main_system_config_reg(regs[0]),
    .sleep_control_reg(regs[1]), .clock_and_key_control_reg(regs[2]),
    .peripheral_gating_reg(regs[3]), .reset_config_reg(regs[4]),
    .clock_select_field(csel), .slowdown_select(slow), .pll_run(pll),
    .initialised(ini), .unlocked(unl));
  wire [37:0] seen = {ini, unl, slow, pll, csel, rd_data, regs[rd_sel]};
  task complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task cmp(input logic [37:0] got, input logic [37:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] read word exp %h seen %h", exp, got);
    end
  endtask : cmp
  always @(posedge core_clk) if (rd_go) cmp(seen, q.pop_front());
  task rd(input int s, input bit u);
    @(negedge core_clk);
    rd_sel = s[2:0];
    q.push_back({init, u, m[2][9:8] != 2'h0, m[2][9:8] <= 2'h1, m[2][9:8],
      m[s], m[s]});
    rd_go = 1'b1;
    @(negedge core_clk);
    rd_go = 1'b0;
  endtask : rd
  task rd_all;
    for (int s = 0; s < 5; s++) rd(s, 1'b0);
  endtask : rd_all
  task wr(input logic [2:0] s, input logic [15:0] d, input logic [1:0] k,
      input bit ok);
    @(negedge core_clk);
    {wr_en, done, wr_sel, wr_data, wr_kind} = {2'h3, s, d, k};
    @(negedge core_clk);
    {wr_en, done} = 2'h0;
    if (ok) m[s] = d;
    else if (s == 3'h2 && init) m[2][3:0] = d[3:0];
    if (ok && init) m[2][3:0] = 4'h0;
  endtask : wr
  task grant(input logic [2:0] s, input logic [15:0] d, input logic [1:0] k2,
      input int extra, input bit ok);
    // key cleared first so the rmw key step lands exactly
    wr(3'h2, {m[2][15:4], 4'h0}, 2'h0, 0);
    @(negedge core_clk);
    lock = 1'b1;
    wr(3'h2, {m[2][15:4], 4'h9}, 2'h1, 0);
    wr(3'h2, {m[2][15:4], 4'h3}, k2, 0);
    wr(3'h2, {m[2][15:4], 4'h7}, 2'h2, 0);
    rd(2, k2 == 2'h0);
    // -1 drops the lock for a cycle, above 0 retires extra instructions
    if (extra == -1) begin
      @(negedge core_clk);
      lock = 1'b0;
      @(negedge core_clk);
      lock = 1'b1;
    end
    repeat (extra > 0 ? extra : 0) begin
      @(negedge core_clk);
      done = 1'b1;
      @(negedge core_clk);
      done = 1'b0;
    end
    // -2 makes the protected write an access of no allowed kind
    wr(s, d, extra == -2 ? 2'h3 : 2'(s % 3'h3), ok);
    @(negedge core_clk);
    lock = 1'b0;
  endtask : grant
  initial begin
    void'($urandom(32'he4f9));
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    for (int s = 0; s < 5; s++) wr(s[2:0], 16'($urandom), 2'h0, 1);
    rd_all;
    @(negedge core_clk);
    eoi = 1'b1;
    @(negedge core_clk);
    eoi = 1'b0;
    init = 1'b1;
    for (int s = 0; s < 5; s++) wr(s[2:0], 16'($urandom), 2'h1, 0);
    rd_all;
    grant(3'h2, 16'h010f, 2'h0, 0, 1);
    rd_all;
    wr(3'h3, 16'h1234, 2'h0, 0);
    for (int s = 1; s < 5; s++) begin
      grant(s[2:0], 16'($urandom), 2'h0, 0, 1);
    end
    grant(3'h2, 16'h0000, 2'h0, 0, 1);
    rd_all;
    grant(3'h3, 16'hbeef, 2'h1, 0, 0);
    grant(3'h4, 16'hbeef, 2'h0, 1, 0);
    grant(3'h0, 16'hbeef, 2'h0, 0, 0);
    grant(3'h1, 16'hbeef, 2'h0, -1, 0);
    grant(3'h1, 16'hbeef, 2'h0, -2, 0);
    rd_all;
    complete_run;
  end
  initial begin
    #50000;
    errors++;
    complete_run;
  end
endmodule : secured_register_unlock_tb_top
`default_nettype wire
